// ==== src/fpa_cfg.svh ====
// Constants for the function partition assignment block: sizes, offsets, fields, reset values
`ifndef FPA_CFG_SVH
`define FPA_CFG_SVH
`define FPA_WORD_W 32
`define FPA_MAX_CH 8
`define FPA_MAX_BUS 4
`define FPA_MULTI_HOST 1'b1
`define FPA_HDR_WORDS 3'h4
`define FPA_CMD_SET_PF 8'h28
`define FPA_PKG_CHAN 5'h1F
// Header word 1 carries packet type in [31:24] and channel id in [23:16]
`define FPA_HDR_TYPE_MSB 31
`define FPA_HDR_TYPE_LSB 24
`define FPA_HDR_PKG_MSB 23
`define FPA_HDR_PKG_LSB 21
`define FPA_HDR_ICH_MSB 20
`define FPA_HDR_ICH_LSB 16
// Register byte offsets
`define FPA_OFF_CFG 8'h00
`define FPA_OFF_STATUS 8'h04
`define FPA_OFF_SEL 8'h08
`define FPA_OFF_PIDX 8'h0C
`define FPA_OFF_ACT_EN 8'h10
`define FPA_OFF_ACT_CH 8'h14
`define FPA_OFF_ACT_BUS 8'h18
`define FPA_OFF_PEND_EN 8'h1C
`define FPA_OFF_PEND_CH 8'h20
`define FPA_OFF_PEND_BUS 8'h24
`define FPA_OFF_PCNT 8'h28
// Reset values: one channel, one bus, 32 functions, 1 enabled, package 0
`define FPA_RST_CH_CNT 4'h1
`define FPA_RST_BUS_CNT 3'h1
`define FPA_RST_FN_CNT 6'h20
`define FPA_RST_EN_CNT 6'h01
`define FPA_RST_PKG_ID 3'h0
`define FPA_RST_SEL_CH 3'h0
`define FPA_RST_SEL_FN 5'h00
`endif

// ==== src/fpa_pkg.sv ====
// Types for the function partition assignment block
`include "fpa_cfg.svh"
package fpa_pkg;
	typedef enum logic [2:0] {PIdle, PHdr, PChan, PEnab, PBus, PTail, PSkip} fpa_parse_e;
	typedef enum logic [2:0] {ErrNone, ErrShort, ErrCount, ErrHighBits, ErrConfig} fpa_err_e;
	typedef logic [`FPA_WORD_W-1:0] fpa_word_t;
	typedef fpa_word_t [`FPA_MAX_CH-1:0] fpa_chmap_t;
	typedef fpa_word_t [`FPA_MAX_BUS-1:0] fpa_busmap_t;
	typedef struct packed {
		logic sop;
		logic eop;
		logic valid;
		fpa_word_t data;
	} fpa_rxword_s;
	typedef struct packed {
		logic [3:0] chCnt;
		logic [2:0] busCnt;
		logic [5:0] fnCnt;
		logic [5:0] enCnt;
		logic [2:0] pkgId;
	} fpa_cfg_s;
	typedef struct packed {
		fpa_chmap_t ch;
		fpa_word_t en;
		fpa_busmap_t bus;
	} fpa_maps_s;
	typedef struct packed {
		fpa_cfg_s cfg;
		logic [2:0] selCh;
		logic [4:0] selFn;
		fpa_parse_e parse;
		logic [2:0] hdrIdx;
		logic [3:0] wordIdx;
		fpa_err_e err;
		fpa_maps_s shadow;
		fpa_maps_s pend;
		fpa_maps_s act;
		logic pending;
		logic lastOk;
		fpa_err_e lastErr;
		logic [7:0] okCount;
		logic [2:0] rstSync;
		logic rstLvl;
		logic applied;
		logic accepted;
		logic rejected;
		logic waitReq;
		fpa_word_t readData;
	} fpa_state_s;
endpackage : fpa_pkg

// ==== src/fpa_top.sv ====
// Set PF Assignment command handling, pending/active function maps and partition index lookup
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "fpa_cfg.svh"
module fpa_top (
	input wire logic mclk,
	input wire logic rst,
	input wire fpa_pkg::fpa_rxword_s rxWord,
	input wire logic pciRst_n,
	input wire logic [7:0] avAddress,
	input wire logic avRead,
	input wire logic avWrite,
	input wire logic [3:0] avByteEnable,
	input wire logic [31:0] avWriteData,
	output logic [31:0] avReadData,
	output logic avWaitRequest,
	output fpa_pkg::fpa_maps_s activeMaps,
	output logic configApplied,
	output logic cmdAccepted,
	output logic cmdRejected
);
	fpa_pkg::fpa_state_s s_q;
	fpa_pkg::fpa_state_s s_d;

	////////////////////////////////////////////////////////////////////////////
	function automatic fpa_pkg::fpa_word_t fnMask(input logic [5:0] n);
		fpa_pkg::fpa_word_t m;
		m = '1;
		if (n < 6'h20)
			m = (32'h00000001 << n) - 32'h00000001;
		return m;
	endfunction : fnMask

	function automatic logic [5:0] popCount(input fpa_pkg::fpa_word_t w);
		logic [5:0] n;
		n = 6'h00;
		for (int i = 0; i < `FPA_WORD_W; i++)
			n = n + {5'h00, w[i]};
		return n;
	endfunction : popCount

	// Index = assigned functions at or below f, zero when f not assigned
	function automatic logic [5:0] partIndex(input fpa_pkg::fpa_word_t w, input logic [4:0] f);
		fpa_pkg::fpa_word_t below;
		below = w & ((32'h00000002 << f) - 32'h00000001);
		return w[f] ? popCount(below) : 6'h00;
	endfunction : partIndex

	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : laneMerge

	////////////////////////////////////////////////////////////////////////////
	logic [2:0] busEff;
	logic [3:0] lastCh;
	logic [31:0] cfgWord;
	logic [31:0] selWord;
	logic [31:0] rdMux;
	logic [31:0] merged;
	logic busReq;
	logic busTake;
	fpa_pkg::fpa_word_t mask;
	fpa_pkg::fpa_word_t word;
	logic [7:0] hdrType;
	logic [2:0] hdrPkg;
	logic [4:0] hdrIch;
	logic cfgBad;
	logic [5:0] partCnt [`FPA_MAX_CH];

	// Partitions per committed channel, so software can size its per-partition tables
	for (genvar g = 0; g < `FPA_MAX_CH; g++)
	begin : gPartCnt
		assign partCnt[g] = popCount(s_q.act.ch[g]);
	end

	always_comb
	begin
		s_d = s_q;
		s_d.applied = 1'b0;
		s_d.accepted = 1'b0;
		s_d.rejected = 1'b0;
		word = rxWord.data;
		hdrType = word[`FPA_HDR_TYPE_MSB:`FPA_HDR_TYPE_LSB];
		hdrPkg = word[`FPA_HDR_PKG_MSB:`FPA_HDR_PKG_LSB];
		hdrIch = word[`FPA_HDR_ICH_MSB:`FPA_HDR_ICH_LSB];
		mask = fnMask(s_q.cfg.fnCnt);
		// A part without multi-host support sees one bus whatever is configured
		busEff = `FPA_MULTI_HOST ? s_q.cfg.busCnt : 3'h1;
		lastCh = s_q.cfg.chCnt - 4'h1;
		cfgBad = (s_q.cfg.chCnt == 4'h0) || (s_q.cfg.chCnt > 4'(`FPA_MAX_CH))
			|| (busEff > 3'(`FPA_MAX_BUS));

		// PCI reset pin: three stages, level moves once stages two and three agree
		s_d.rstSync = {s_q.rstSync[1:0], ~pciRst_n};
		if (s_q.rstSync[1] == s_q.rstSync[2])
			s_d.rstLvl = s_q.rstSync[2];
		if (s_d.rstLvl && !s_q.rstLvl && s_q.pending)
		begin
			s_d.act = s_q.pend;
			s_d.pending = 1'b0;
			s_d.applied = 1'b1;
		end

		////////////////////////////////////////////////////////////////////////
		if (rxWord.valid)
		begin
			if (rxWord.sop)
			begin
				s_d.parse = fpa_pkg::PHdr;
				s_d.hdrIdx = 3'h1;
				s_d.err = fpa_pkg::ErrNone;
				s_d.shadow = '0;
			end
			else
			begin
				unique case (s_q.parse)
					fpa_pkg::PIdle, fpa_pkg::PSkip:
						s_d.parse = s_q.parse;
					fpa_pkg::PHdr:
					begin
						// Only the package-level set command for this package is taken
						if (s_q.hdrIdx == 3'h1 && (hdrType != `FPA_CMD_SET_PF
							|| hdrIch != `FPA_PKG_CHAN || hdrPkg != s_q.cfg.pkgId))
							s_d.parse = fpa_pkg::PSkip;
						else if (s_q.hdrIdx == `FPA_HDR_WORDS - 3'h1)
						begin
							s_d.parse = fpa_pkg::PChan;
							s_d.wordIdx = 4'h0;
							if (cfgBad)
								s_d.err = fpa_pkg::ErrConfig;
						end
						s_d.hdrIdx = s_q.hdrIdx + 3'h1;
					end
					fpa_pkg::PChan:
					begin
						if ((word & ~mask) != '0)
							s_d.err = fpa_pkg::ErrHighBits;
						if (!cfgBad)
							s_d.shadow.ch[s_q.wordIdx[2:0]] = word & mask;
						s_d.wordIdx = s_q.wordIdx + 4'h1;
						if (s_q.wordIdx == lastCh)
							s_d.parse = fpa_pkg::PEnab;
					end
					fpa_pkg::PEnab:
					begin
						s_d.shadow.en = word & mask;
						if ((word & ~mask) != '0)
							s_d.err = fpa_pkg::ErrHighBits;
						else if (popCount(word) != s_q.cfg.enCnt)
							s_d.err = fpa_pkg::ErrCount;
						s_d.wordIdx = 4'h0;
						if (busEff > 3'h1)
							s_d.parse = fpa_pkg::PBus;
						else
						begin
							s_d.shadow.bus[0] = mask;
							s_d.parse = fpa_pkg::PTail;
						end
					end
					fpa_pkg::PBus:
					begin
						// No cross-check against channel words: bus-only functions are legal
						s_d.shadow.bus[s_q.wordIdx[1:0]] = word & mask;
						if ((word & ~mask) != '0)
							s_d.err = fpa_pkg::ErrHighBits;
						s_d.wordIdx = s_q.wordIdx + 4'h1;
						if (s_q.wordIdx == {1'b0, busEff} - 4'h1)
							s_d.parse = fpa_pkg::PTail;
					end
					fpa_pkg::PTail:
						s_d.parse = fpa_pkg::PTail;
					default:
						s_d.parse = fpa_pkg::PIdle;
				endcase
			end

			// Frame end: accept only after the checksum word has been seen
			if (rxWord.eop)
			begin
				if (s_q.parse == fpa_pkg::PTail && !rxWord.sop)
				begin
					if (s_q.err == fpa_pkg::ErrNone)
					begin
						s_d.pend = s_q.shadow;
						s_d.pending = 1'b1;
						s_d.okCount = s_q.okCount + 8'h01;
						s_d.accepted = 1'b1;
						s_d.lastOk = 1'b1;
					end
					else
					begin
						s_d.rejected = 1'b1;
						s_d.lastOk = 1'b0;
						s_d.lastErr = s_q.err;
					end
				end
				else if (s_d.parse != fpa_pkg::PSkip && s_d.parse != fpa_pkg::PIdle)
				begin
					s_d.rejected = 1'b1;
					s_d.lastOk = 1'b0;
					s_d.lastErr = fpa_pkg::ErrShort;
				end
				s_d.parse = fpa_pkg::PIdle;
			end
		end

		////////////////////////////////////////////////////////////////////////
		cfgWord = {5'h00, s_q.cfg.pkgId, 2'h0, s_q.cfg.enCnt, 2'h0, s_q.cfg.fnCnt,
			1'b0, s_q.cfg.busCnt, s_q.cfg.chCnt};
		selWord = {19'h00000, s_q.selFn, 5'h00, s_q.selCh};
		unique case (avAddress)
			`FPA_OFF_CFG: rdMux = cfgWord;
			`FPA_OFF_STATUS: rdMux = {16'h0000, s_q.okCount, 1'b0, s_q.lastErr,
				1'b0, s_q.lastOk, 1'b0, s_q.pending};
			`FPA_OFF_SEL: rdMux = selWord;
			`FPA_OFF_PIDX: rdMux = {26'h0000000, partIndex(s_q.act.ch[s_q.selCh], s_q.selFn)};
			`FPA_OFF_ACT_EN: rdMux = s_q.act.en;
			`FPA_OFF_ACT_CH: rdMux = ({1'b0, s_q.selCh} < s_q.cfg.chCnt) ?
				s_q.act.ch[s_q.selCh] : 32'h00000000;
			// Bus words beyond the enabled bus count read as zero
			`FPA_OFF_ACT_BUS: rdMux = ({1'b0, s_q.selFn[1:0]} < busEff) ?
				s_q.act.bus[s_q.selFn[1:0]] : 32'h00000000;
			`FPA_OFF_PEND_EN: rdMux = s_q.pend.en;
			`FPA_OFF_PEND_CH: rdMux = s_q.pend.ch[s_q.selCh];
			`FPA_OFF_PEND_BUS: rdMux = s_q.pend.bus[s_q.selFn[1:0]];
			`FPA_OFF_PCNT: rdMux = ({1'b0, s_q.selCh} < s_q.cfg.chCnt) ?
				{26'h0000000, partCnt[s_q.selCh]} : 32'h00000000;
			default: rdMux = 32'h00000000;
		endcase

		// One wait cycle per access; read data is captured as waitrequest falls, writes take effect as it rises again
		busReq = avRead || avWrite;
		busTake = busReq && !s_q.waitReq;
		s_d.waitReq = !(busReq && s_q.waitReq);
		if (busReq && s_q.waitReq && avRead)
			s_d.readData = rdMux;
		merged = 32'h00000000;
		if (busTake && avWrite)
		begin
			if (avAddress == `FPA_OFF_CFG)
			begin
				merged = laneMerge(cfgWord, avWriteData, avByteEnable);
				s_d.cfg.chCnt = merged[3:0];
				s_d.cfg.busCnt = merged[6:4];
				s_d.cfg.fnCnt = merged[13:8];
				s_d.cfg.enCnt = merged[21:16];
				s_d.cfg.pkgId = merged[26:24];
			end
			else if (avAddress == `FPA_OFF_SEL)
			begin
				merged = laneMerge(selWord, avWriteData, avByteEnable);
				s_d.selCh = merged[2:0];
				s_d.selFn = merged[12:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			s_q <= '0;
			s_q.cfg.chCnt <= `FPA_RST_CH_CNT;
			s_q.cfg.busCnt <= `FPA_RST_BUS_CNT;
			s_q.cfg.fnCnt <= `FPA_RST_FN_CNT;
			s_q.cfg.enCnt <= `FPA_RST_EN_CNT;
			s_q.cfg.pkgId <= `FPA_RST_PKG_ID;
			s_q.selCh <= `FPA_RST_SEL_CH;
			s_q.selFn <= `FPA_RST_SEL_FN;
			s_q.parse <= fpa_pkg::PIdle;
			s_q.err <= fpa_pkg::ErrNone;
			s_q.lastErr <= fpa_pkg::ErrNone;
			s_q.waitReq <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign avReadData = s_q.readData;
	assign avWaitRequest = s_q.waitReq;
	assign activeMaps = s_q.act;
	assign configApplied = s_q.applied;
	assign cmdAccepted = s_q.accepted;
	assign cmdRejected = s_q.rejected;
endmodule : fpa_top

// ==== tb/fpa_checker.sv ====
// Assertion checker for the function partition assignment block
`timescale 1ns/10ps
module fpa_checker (
	input wire logic mclk,
	input wire logic rst,
	input wire fpa_pkg::fpa_rxword_s rxWord,
	input wire logic pciRst_n,
	input wire logic [7:0] avAddress,
	input wire logic avRead,
	input wire logic avWrite,
	input wire logic [3:0] avByteEnable,
	input wire logic [31:0] avWriteData,
	input wire logic [31:0] avReadData,
	input wire logic avWaitRequest,
	input wire fpa_pkg::fpa_maps_s activeMaps,
	input wire logic configApplied,
	input wire logic cmdAccepted,
	input wire logic cmdRejected
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	sequence avTake;
		(avRead || avWrite) && avWaitRequest;
	endsequence
	sequence frameEnd;
		rxWord.valid && rxWord.eop ##1 (cmdAccepted || cmdRejected);
	endsequence
	oneVerdict_a: assert property (!(cmdAccepted && cmdRejected))
		else $error("accept and reject together");
	verdictAtEop_a: assert property ((cmdAccepted || cmdRejected) |-> $past(rxWord.valid && rxWord.eop))
		else $error("verdict without end of frame");
	verdictPulse_a: assert property (cmdAccepted |=> !cmdAccepted)
		else $error("accept pulse too long");
	mapsHeld_a: assert property (!configApplied |-> $stable(activeMaps))
		else $error("active maps changed without commit");
	commitAfterPin_a: assert property (configApplied |-> !$past(pciRst_n, 2))
		else $error("commit without reset pin");
	commitPulse_a: assert property (configApplied |=> !configApplied)
		else $error("commit pulse too long");
	busAnswer_a: assert property (avTake |=> !avWaitRequest)
		else $error("no answer one cycle after request");
	answerOne_a: assert property (!avWaitRequest |=> avWaitRequest)
		else $error("waitrequest low too long");
	answerCause_a: assert property ($fell(avWaitRequest) |-> $past(avRead || avWrite))
		else $error("answer without request");
	frameSeen_c: cover property (frameEnd);
endmodule : fpa_checker
bind fpa_top fpa_checker chk_u (.mclk(mclk), .rst(rst), .rxWord(rxWord), .pciRst_n(pciRst_n),
	.avAddress(avAddress), .avRead(avRead), .avWrite(avWrite), .avByteEnable(avByteEnable),
	.avWriteData(avWriteData), .avReadData(avReadData), .avWaitRequest(avWaitRequest),
	.activeMaps(activeMaps), .configApplied(configApplied), .cmdAccepted(cmdAccepted),
	.cmdRejected(cmdRejected));

// ==== tb/fpa_mc_model.sv ====
// Management controller model sending command frames on the packet link
`timescale 1ns/10ps
module fpa_mc_model (
	input wire logic mclk,
	output fpa_pkg::fpa_rxword_s rxWord
);
	fpa_pkg::fpa_word_t pl[$];
	initial rxWord = '0;
	// Idle words carry the inverse of the last data so stale values never match
	task automatic put(input logic s, input logic e, input fpa_pkg::fpa_word_t d, input int gap);
		rxWord <= '{sop: s, eop: e, valid: 1'b1, data: d};
		@(posedge mclk);
		if (gap > 0)
		begin
			rxWord <= '{sop: 1'b0, eop: 1'b0, valid: 1'b0, data: ~d};
			repeat (gap) @(posedge mclk);
		end
	endtask : put
	task automatic frame(input logic [7:0] cmd, input int gap, input bit cut);
		put(1'b1, 1'b0, 32'h0000_0000, gap);
		put(1'b0, 1'b0, {cmd, 3'h0, 5'h1F, 16'h0000}, gap);
		put(1'b0, 1'b0, 32'h0000_0000, gap);
		put(1'b0, 1'b0, 32'h0000_0000, gap);
		foreach (pl[i])
			put(1'b0, cut && (i == pl.size() - 1), pl[i], gap + (cut ? 1 : 0));
		if (!cut)
			put(1'b0, 1'b1, 32'hA5A5_5A5A, gap + 1);
		pl.delete();
	endtask : frame
endmodule : fpa_mc_model

// ==== tb/tb.sv ====
// Self-checking testbench for the function partition assignment block
`timescale 1ns/10ps
module tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic pciRst_n = 1'b1;
	logic [7:0] avAddress = 8'h00;
	logic avRead = 1'b0;
	logic avWrite = 1'b0;
	logic [3:0] avByteEnable = 4'hF;
	logic [31:0] avWriteData = 32'h0000_0000;
	logic [31:0] avReadData;
	logic avWaitRequest;
	fpa_pkg::fpa_rxword_s rxWord;
	fpa_pkg::fpa_maps_s activeMaps;
	logic configApplied;
	logic cmdAccepted;
	logic cmdRejected;
	logic [31:0] rdv;
	int fail_count = 0;
	int checks = 0;
	int nAcc = 0;
	int nRej = 0;
	fpa_top dut_u (.mclk(mclk), .rst(rst), .rxWord(rxWord), .pciRst_n(pciRst_n),
		.avAddress(avAddress), .avRead(avRead), .avWrite(avWrite), .avByteEnable(avByteEnable),
		.avWriteData(avWriteData), .avReadData(avReadData), .avWaitRequest(avWaitRequest),
		.activeMaps(activeMaps), .configApplied(configApplied), .cmdAccepted(cmdAccepted),
		.cmdRejected(cmdRejected));
	fpa_mc_model mc_u (.mclk(mclk), .rxWord(rxWord));
	initial forever #50 mclk = ~mclk;
	always @(posedge mclk)
	begin
		nAcc += (cmdAccepted === 1'b1);
		nRej += (cmdRejected === 1'b1);
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Request held until waitrequest is sampled low; one idle edge before the next
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		avAddress <= a;
		avWrite <= w;
		avRead <= !w;
		avWriteData <= d;
		for (i = 0; i < 20; i++)
		begin
			@(posedge mclk);
			if (avWaitRequest === 1'b0)
				break;
		end
		rdv = avReadData;
		avRead <= 1'b0;
		avWrite <= 1'b0;
		@(posedge mclk);
		if (i == 20)
		begin
			fail_count++;
			summarize();
		end
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		bus(1'b0, a, 32'h0000_0000);
		chk(n, e, rdv);
	endtask : rd
	task automatic send(input fpa_pkg::fpa_word_t q[$], input logic [7:0] cmd, input bit cut,
		input int gap, input int ea, input int er);
		int a0;
		int r0;
		a0 = nAcc;
		r0 = nRej;
		mc_u.pl = q;
		mc_u.frame(cmd, gap, cut);
		repeat (3) @(posedge mclk);
		chk("accepted", ea, nAcc - a0);
		chk("rejected", er, nRej - r0);
	endtask : send
	task automatic commit();
		int i;
		pciRst_n <= 1'b0;
		for (i = 0; i < 20 && configApplied !== 1'b1; i++)
			@(posedge mclk);
		pciRst_n <= 1'b1;
		repeat (6) @(posedge mclk);
		chk("applied", 1, i < 20);
	endtask : commit
	////////////////////////////////////////////////////////////////////////////////
	task automatic s_reset();
		rd(8'h00, 32'h0001_2011, "cfg reset");
		rd(8'hF0, 32'h0000_0000, "unmapped");
		bus(1'b1, 8'h04, 32'hFFFF_FFFF);
		rd(8'h04, 32'h0000_0000, "status ro");
		chk("act en reset", 32'h0, activeMaps.en);
	endtask : s_reset
	task automatic s_basic();
		bus(1'b1, 8'h00, 32'h0002_0812);
		send('{32'h44, 32'h03, 32'h05}, 8'h28, 1'b0, 0, 1, 0);
		chk("act en early", 32'h0, activeMaps.en);
		rd(8'h1C, 32'h05, "pend en");
		commit();
		chk("act ch0", 32'h44, activeMaps.ch[0]);
		chk("act en", 32'h05, activeMaps.en);
		chk("act bus0", 32'hFF, activeMaps.bus[0]);
		bus(1'b1, 8'h08, 32'h0000_0200);
		rd(8'h0C, 32'h1, "pidx f2");
		// Only the function byte is enabled, so the channel field must stay at 0
		avByteEnable <= 4'h2;
		bus(1'b1, 8'h08, 32'h0000_0607);
		avByteEnable <= 4'hF;
		rd(8'h0C, 32'h2, "pidx f6");
		bus(1'b1, 8'h08, 32'h0000_0101);
		rd(8'h0C, 32'h2, "pidx ch1 f1");
		rd(8'h28, 32'h2, "pcnt ch1");
		rd(8'h20, 32'h03, "pend ch1");
	endtask : s_basic
	task automatic s_reject();
		send('{32'h44, 32'h03, 32'h01}, 8'h28, 1'b0, 0, 0, 1);
		send('{32'h144, 32'h03, 32'h05}, 8'h28, 1'b0, 0, 0, 1);
		send('{32'h44, 32'h03, 32'h05}, 8'h28, 1'b1, 0, 0, 1);
		send('{32'h44, 32'h03, 32'h05}, 8'h27, 1'b0, 0, 0, 0);
		rd(8'h1C, 32'h05, "pend kept");
		rd(8'h04, 32'h0000_0110, "status rej");
	endtask : s_reject
	task automatic s_multi();
		bus(1'b1, 8'h00, 32'h0002_0822);
		send('{32'h02, 32'h00, 32'h05, 32'h0F, 32'hF0}, 8'h28, 1'b0, 2, 1, 0);
		commit();
		chk("bus0", 32'h0F, activeMaps.bus[0]);
		chk("bus1", 32'hF0, activeMaps.bus[1]);
		bus(1'b1, 8'h08, 32'h0000_0100);
		rd(8'h18, 32'hF0, "bus1 read");
		rd(8'h24, 32'hF0, "pend bus1");
		rd(8'h28, 32'h1, "pcnt ch0");
	endtask : s_multi
	initial
	begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		s_reset();
		s_basic();
		s_reject();
		s_multi();
		summarize();
	end
endmodule : tb
